/* rtl/tfcs_defines.vh */
// constants for the tape formatter command sequencer
`ifndef TFCS_DEFINES_VH
`define TFCS_DEFINES_VH
`define TFCS_ST_REST      3'h0
`define TFCS_ST_PRE       3'h1
`define TFCS_ST_PRE_LONG  3'h2
`define TFCS_ST_XFER      3'h3
`define TFCS_ST_POST      3'h4
`define TFCS_ST_HALT_FWD  3'h5
`define TFCS_ST_HALT_REV  3'h6
`define TFCS_ST_REWIND    3'h7
`define TFCS_OP_NONE      4'h0
`define TFCS_OP_READ      4'h1
`define TFCS_OP_WRITE     4'h2
`define TFCS_OP_SPACE     4'h3
`define TFCS_OP_MARK      4'h4
`define TFCS_OP_ERASE     4'h5
`define TFCS_OP_REWIND    4'h6
`define TFCS_OP_OFFLINE   4'h7
`define TFCS_OP_REW_OFL   4'h8
`define TFCS_OP_CLEAR     4'h9
`define TFCS_CNT_W        16
`define TFCS_PRE_CYC      16'h0100
`define TFCS_PRE_LONG_CYC 16'h1000
`define TFCS_POST_CYC     16'h0080
`define TFCS_HALT_CYC     16'h0200
`define TFCS_IRG_CYC      16'h0040
`endif

/* rtl/tfcs_sequencer.v */
// command decode and state sequencing for a tape formatter
// Function
// - latch command lines on the strobe
// - rest state 0; invalid strobes ignored
// - offline, rewind-offline pass through, no busy; plain rewind too only if REWIND_BUSY_OPTION is 0
// - busy rewind/clear waits in 7 until done
// - enter predelay 1 or 2, drive motion
// - state 3: write to halt, erase, mark
// - dual-gap unit waits for gap start
// - read/space hold 3 until record gap
// - data busy in 3,4; motion 1 to 4
// - halt delay 5/6 then idle in 0
// - read/write accepted during halt delay
// - other busy states reject all but clear; state 7 still passes offline
// - delay counter runs in 1,2,4,5,6; gap count in 3
// - clear accepted while busy, resets status
// - rewind to load point, optional busy
// - offline never busy, sent while rewinding
// - read/space modes and diagnostic read
// - single or multi-record space, stop at start
// - gap erase alone or before write/mark
// - decode combined command line patterns
`timescale 1ns/10ps
`include "tfcs_defines.vh"
module tfcs_sequencer #(
  parameter REWIND_BUSY_OPTION = 1
) (
  input  wire       i_clk,
  input  wire       i_srst,
  input  wire       i_command_strobe,
  input  wire       i_backward_select,
  input  wire       i_write_record_cmd,
  input  wire       i_filemark_write_cmd,
  input  wire       i_gap_erase_cmd,
  input  wire       i_forward_skip_cmd,
  input  wire       i_read_record_cmd,
  input  wire       i_clear_cmd,
  input  wire       i_tape_return_cmd,
  input  wire       i_unit_offline_cmd,
  input  wire       i_threshold_high_mode,
  input  wire       i_threshold_low_mode,
  input  wire       i_edit_mode,
  input  wire       i_diagnostic_readback_mode,
  input  wire       i_stop_space_n,
  input  wire       i_halt,
  input  wire       i_tape_start_marker,
  input  wire       i_dual_gap_unit,
  input  wire       i_unit_rewinding,
  input  wire       i_read_activity,
  input  wire       i_mark_done,
  output reg        o_command_busy_flag,
  output reg        o_transfer_active_flag,
  output reg        o_forward_motion_request,
  output reg        o_backward_motion_request,
  output reg        o_write_enable,
  output reg        o_rewind_pulse,
  output reg        o_offline_pulse,
  output reg        o_status_clear,
  output reg        o_threshold_high,
  output reg        o_threshold_low,
  output reg        o_diag_readback,
  output reg        o_edit,
  output reg  [2:0] o_state
);
  reg  [2:0]            state_q;
  reg  [2:0]            state_d;
  reg  [3:0]            op_q;
  reg  [3:0]            op_d;
  reg                   rev_q;
  reg                   rev_d;
  reg                   gap_q;
  reg                   gap_d;
  reg  [`TFCS_CNT_W-1:0] cnt_q;
  reg  [`TFCS_CNT_W-1:0] cnt_d;
  reg                   halt_seen_q;
  reg  [3:0]            dec_op;
  reg                   dec_rev;
  reg                   dec_gap;
  reg  [`TFCS_CNT_W-1:0] limit;
  wire                  timer_done;
  wire                  accept;
  wire                  busy_state;
  wire                  halt_delay;
  wire                  rw_cmd;
  wire                  irg_seen;

  // command line decode, single lines and combined patterns
  always @* begin
    dec_op  = `TFCS_OP_NONE;
    dec_rev = 1'b0;
    dec_gap = 1'b0;
    case ({i_backward_select, i_write_record_cmd, i_filemark_write_cmd,
           i_gap_erase_cmd, i_forward_skip_cmd, i_read_record_cmd,
           i_clear_cmd, i_tape_return_cmd, i_unit_offline_cmd})
      9'h008: dec_op = `TFCS_OP_READ;
      9'h108: begin
        dec_op  = `TFCS_OP_READ;
        dec_rev = 1'b1;
      end
      9'h010: dec_op = `TFCS_OP_SPACE;
      9'h100: begin
        dec_op  = `TFCS_OP_SPACE;
        dec_rev = 1'b1;
      end
      9'h080: dec_op = `TFCS_OP_WRITE;
      9'h0a0: begin
        dec_op  = `TFCS_OP_WRITE;
        dec_gap = 1'b1;
      end
      9'h040: dec_op = `TFCS_OP_MARK;
      9'h060: begin
        dec_op  = `TFCS_OP_MARK;
        dec_gap = 1'b1;
      end
      9'h020: begin
        dec_op  = `TFCS_OP_ERASE;
        dec_gap = 1'b1;
      end
      9'h002: dec_op = `TFCS_OP_REWIND;
      9'h001: dec_op = `TFCS_OP_OFFLINE;
      9'h003: dec_op = `TFCS_OP_REW_OFL;
      9'h004: dec_op = `TFCS_OP_CLEAR;
      default: dec_op = `TFCS_OP_NONE;
    endcase
  end

  assign busy_state = o_command_busy_flag;
  assign halt_delay = (state_q == `TFCS_ST_HALT_FWD) ||
                      (state_q == `TFCS_ST_HALT_REV);
  assign rw_cmd     = (dec_op == `TFCS_OP_READ) ||
                      (dec_op == `TFCS_OP_WRITE);
  // busy rejects all but clear, except the halt-delay special exit
  assign accept = i_command_strobe && (dec_op != `TFCS_OP_NONE) &&
                  (!busy_state || dec_op == `TFCS_OP_CLEAR ||
                   (halt_delay && rw_cmd));

  always @* begin
    case (state_q)
      `TFCS_ST_PRE:      limit = `TFCS_PRE_CYC;
      `TFCS_ST_PRE_LONG: limit = `TFCS_PRE_LONG_CYC;
      `TFCS_ST_POST:     limit = `TFCS_POST_CYC;
      default:           limit = `TFCS_HALT_CYC;
    endcase
  end
  assign timer_done = (cnt_q == limit);
  // gap seen once read activity has been absent long enough
  assign irg_seen = (cnt_q == `TFCS_IRG_CYC);

  always @* begin
    state_d = state_q;
    op_d    = op_q;
    rev_d   = rev_q;
    gap_d   = gap_q;
    cnt_d   = `TFCS_CNT_W'h0;
    case (state_q)
      `TFCS_ST_PRE, `TFCS_ST_PRE_LONG: begin
        cnt_d = cnt_q + `TFCS_CNT_W'h1;
        if (timer_done) begin
          state_d = `TFCS_ST_XFER;
          cnt_d   = `TFCS_CNT_W'h0;
        end
      end
      `TFCS_ST_XFER: begin
        // counter reused as gap detector, reset by read activity
        if (!i_read_activity)
          cnt_d = irg_seen ? cnt_q : cnt_q + `TFCS_CNT_W'h1;
        case (op_q)
          `TFCS_OP_ERASE: state_d = `TFCS_ST_POST;
          `TFCS_OP_WRITE, `TFCS_OP_MARK: begin
            if (halt_seen_q && (!i_dual_gap_unit || irg_seen))
              state_d = `TFCS_ST_POST;
          end
          default: begin
            if (rev_q && i_tape_start_marker)
              state_d = `TFCS_ST_POST;
            else if (irg_seen && i_stop_space_n)
              state_d = `TFCS_ST_POST;
          end
        endcase
        if (state_d == `TFCS_ST_POST)
          cnt_d = `TFCS_CNT_W'h0;
      end
      `TFCS_ST_POST: begin
        cnt_d = cnt_q + `TFCS_CNT_W'h1;
        if (timer_done) begin
          state_d = rev_q ? `TFCS_ST_HALT_REV : `TFCS_ST_HALT_FWD;
          cnt_d   = `TFCS_CNT_W'h0;
        end
      end
      `TFCS_ST_HALT_FWD, `TFCS_ST_HALT_REV: begin
        cnt_d = cnt_q + `TFCS_CNT_W'h1;
        if (timer_done) begin
          state_d = `TFCS_ST_REST;
          op_d    = `TFCS_OP_NONE;
        end
      end
      `TFCS_ST_REWIND: begin
        if (!i_unit_rewinding) begin
          state_d = `TFCS_ST_REST;
          op_d    = `TFCS_OP_NONE;
        end
      end
      default: state_d = `TFCS_ST_REST;
    endcase
    if (accept) begin
      cnt_d = `TFCS_CNT_W'h0;
      case (dec_op)
        `TFCS_OP_OFFLINE, `TFCS_OP_REW_OFL: state_d = state_q;
        `TFCS_OP_REWIND: begin
          if (REWIND_BUSY_OPTION != 0) begin
            state_d = `TFCS_ST_REWIND;
            op_d    = dec_op;
          end
        end
        `TFCS_OP_CLEAR: begin
          state_d = `TFCS_ST_REWIND;
          op_d    = dec_op;
        end
        default: begin
          state_d = (i_tape_start_marker || dec_gap) ?
                    `TFCS_ST_PRE_LONG : `TFCS_ST_PRE;
          op_d    = dec_op;
          rev_d   = dec_rev;
          gap_d   = dec_gap;
        end
      endcase
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      state_q     <= `TFCS_ST_REST;
      op_q        <= `TFCS_OP_NONE;
      rev_q       <= 1'b0;
      gap_q       <= 1'b0;
      cnt_q       <= `TFCS_CNT_W'h0;
      halt_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      rev_q   <= rev_d;
      gap_q   <= gap_d;
      cnt_q   <= cnt_d;
      // halt ends writes; a mark is held so a dual-gap wait keeps it
      if (accept)
        halt_seen_q <= 1'b0;
      else if (state_q == `TFCS_ST_XFER &&
               (op_q == `TFCS_OP_MARK ? i_mark_done : i_halt))
        halt_seen_q <= 1'b1;
    end
  end

  // all outputs registered; state flags from next state, pulses from the strobe
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_command_busy_flag       <= 1'b0;
      o_transfer_active_flag    <= 1'b0;
      o_forward_motion_request  <= 1'b0;
      o_backward_motion_request <= 1'b0;
      o_write_enable            <= 1'b0;
      o_rewind_pulse            <= 1'b0;
      o_offline_pulse           <= 1'b0;
      o_status_clear            <= 1'b0;
      o_threshold_high          <= 1'b0;
      o_threshold_low           <= 1'b0;
      o_diag_readback           <= 1'b0;
      o_edit                    <= 1'b0;
      o_state                   <= `TFCS_ST_REST;
    end else begin
      o_command_busy_flag       <= (state_d != `TFCS_ST_REST);
      o_transfer_active_flag    <= (state_d == `TFCS_ST_XFER) ||
                                   (state_d == `TFCS_ST_POST);
      o_forward_motion_request  <= !rev_d && state_d >= `TFCS_ST_PRE &&
                                   state_d <= `TFCS_ST_POST;
      o_backward_motion_request <= rev_d && state_d >= `TFCS_ST_PRE &&
                                   state_d <= `TFCS_ST_POST;
      o_write_enable            <= (op_d == `TFCS_OP_WRITE) ||
                                   (op_d == `TFCS_OP_MARK) ||
                                   (op_d == `TFCS_OP_ERASE);
      o_rewind_pulse            <= accept && (dec_op == `TFCS_OP_REWIND ||
                                   dec_op == `TFCS_OP_REW_OFL);
      // offline still reaches a unit that is busy rewinding
      o_offline_pulse           <= i_command_strobe &&
                                   (dec_op == `TFCS_OP_OFFLINE ||
                                    dec_op == `TFCS_OP_REW_OFL) &&
                                   (!busy_state ||
                                    state_q == `TFCS_ST_REWIND);
      o_status_clear            <= accept && !(dec_op == `TFCS_OP_OFFLINE ||
                                   dec_op == `TFCS_OP_REW_OFL);
      // mode lines are passed live, not latched; diag readback only on forward read
      o_threshold_high          <= i_threshold_high_mode;
      o_threshold_low           <= i_threshold_low_mode;
      o_diag_readback           <= i_diagnostic_readback_mode &&
                                   op_d == `TFCS_OP_READ && !rev_d;
      o_edit                    <= i_edit_mode;
      o_state                   <= state_d;
    end
  end
endmodule // tfcs_sequencer

/* verification/tfcs_seq_chk_assertions.sv */
// assertion checker bound to the command sequencer
`timescale 1ns/10ps
module tfcs_seq_chk (
  input wire       i_clk, i_srst, i_command_strobe, i_backward_select,
  input wire       i_write_record_cmd, i_filemark_write_cmd, i_gap_erase_cmd,
  input wire       i_forward_skip_cmd, i_read_record_cmd, i_clear_cmd,
  input wire       i_tape_return_cmd, i_unit_offline_cmd, i_unit_rewinding,
  input wire       o_command_busy_flag, o_transfer_active_flag,
  input wire       o_forward_motion_request, o_backward_motion_request,
  input wire       o_offline_pulse, o_status_clear,
  input wire [2:0] o_state
);
  wire [8:0] cv = {i_backward_select, i_write_record_cmd, i_filemark_write_cmd,
    i_gap_erase_cmd, i_forward_skip_cmd, i_read_record_cmd, i_clear_cmd,
    i_tape_return_cmd, i_unit_offline_cmd};
  wire       go = i_command_strobe;
  wire       mv = o_forward_motion_request || o_backward_motion_request;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence idle_go; o_state == 3'h0 && go; endsequence
  sequence halt_rd; o_state inside {3'h5, 3'h6} && go && cv == 9'h008;
  endsequence
  busy_state_a:
    assert property (o_command_busy_flag == (o_state != 3'h0))
    else $error("busy flag disagrees with state");
  data_busy_a:
    assert property (o_transfer_active_flag == (o_state inside {3'h3, 3'h4}))
    else $error("data busy outside states 3 and 4");
  motion_span_a:
    assert property (mv == (o_state inside {3'h1, 3'h2, 3'h3, 3'h4}))
    else $error("motion request outside states 1 to 4");
  invalid_cmd_a:
    assert property (idle_go ##0 (!$onehot(cv) && !(cv inside {9'h003,
      9'h0a0, 9'h060, 9'h108})) |=> o_state == 3'h0 && !o_command_busy_flag)
    else $error("invalid command was taken");
  offline_idle_a:
    assert property (idle_go ##0 cv == 9'h001
      |=> o_state == 3'h0 && o_offline_pulse)
    else $error("offline left rest state");
  clear_take_a:
    assert property (go && cv == 9'h004 |=> o_state == 3'h7)
    else $error("clear not taken");
  rewind_end_a:
    assert property (o_state == 3'h7 && !i_unit_rewinding && !go
      |=> o_state == 3'h0)
    else $error("state 7 held without rewinding");
  special_exit_a:
    assert property (halt_rd |=> o_state inside {3'h1, 3'h2})
    else $error("read refused during halt delay");
  read_start_a:
    assert property (idle_go ##0 cv == 9'h008
      |=> o_state inside {3'h1, 3'h2} && o_forward_motion_request)
    else $error("read did not start forward predelay");
  busy_reject_a:
    assert property (o_state inside {3'h1, 3'h3, 3'h4} && go && !i_clear_cmd
      |=> o_state != 3'h2 && o_state != 3'h7 && o_state >= $past(o_state)
      && !o_status_clear)
    else $error("command taken while busy");
endmodule // tfcs_seq_chk
bind tfcs_sequencer tfcs_seq_chk chk_u (.*);

/* verification/tfcs_unit_model.sv */
// far-side model: tape unit read head and rewind status
`timescale 1ns/10ps
module tfcs_unit_model (
  input  wire i_clk,
  input  wire i_xfer,
  input  wire i_wr,
  input  wire i_rew,
  output wire o_rewinding,
  output reg  o_activity = 1'b0,
  output reg  o_mark_done = 1'b0
);
  reg [7:0] cnt_q = 8'h00;
  reg [7:0] rew_q = 8'h00;
  // rewinding shows at once so the busy wait never misses it
  assign o_rewinding = i_rew || rew_q != 8'h00;
  always @(posedge i_clk) begin
    cnt_q <= i_xfer ? cnt_q + 8'h01 : 8'h00;
    // short record of flux, then a gap
    o_activity <= i_xfer && cnt_q < 8'h20 && cnt_q[0];
    o_mark_done <= i_xfer && i_wr && cnt_q == 8'h10;
    rew_q <= i_rew ? 8'h30 : (rew_q != 8'h00 ? rew_q - 8'h01 : 8'h00);
  end
endmodule // tfcs_unit_model

/* verification/test_tfcs_sequencer.sv */
// self-checking bench for the command sequencer
`timescale 1ns/10ps
module test_tfcs_sequencer;
  reg        i_clk, i_srst, i_command_strobe, i_stop_space_n, i_halt;
  reg        i_tape_start_marker, i_dual_gap_unit;
  reg  [8:0] cv;
  reg  [3:0] md;
  wire       i_backward_select, i_write_record_cmd, i_filemark_write_cmd;
  wire       i_gap_erase_cmd, i_forward_skip_cmd, i_read_record_cmd;
  wire       i_clear_cmd, i_tape_return_cmd, i_unit_offline_cmd;
  wire       i_threshold_high_mode, i_threshold_low_mode, i_edit_mode;
  wire       i_diagnostic_readback_mode;
  wire       i_unit_rewinding, i_read_activity, i_mark_done;
  wire       o_command_busy_flag, o_transfer_active_flag, o_write_enable;
  wire       o_forward_motion_request, o_backward_motion_request;
  wire       o_rewind_pulse, o_offline_pulse, o_status_clear, o_edit;
  wire       o_threshold_high, o_threshold_low, o_diag_readback;
  wire [2:0] o_state;
  integer    n_fail = 0;
  integer    n_tests = 0;
  assign {i_backward_select, i_write_record_cmd, i_filemark_write_cmd,
    i_gap_erase_cmd, i_forward_skip_cmd, i_read_record_cmd, i_clear_cmd,
    i_tape_return_cmd, i_unit_offline_cmd} = cv;
  assign {i_threshold_high_mode, i_threshold_low_mode, i_edit_mode,
    i_diagnostic_readback_mode} = md;
  tfcs_sequencer dut_u (.*);
  tfcs_unit_model unit_u (.i_clk(i_clk), .i_xfer(o_transfer_active_flag),
    .i_wr(o_write_enable), .i_rew(o_rewind_pulse),
    .o_rewinding(i_unit_rewinding), .o_activity(i_read_activity),
    .o_mark_done(i_mark_done));
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // lines drop right after the strobe; the latch must hold them
  task cmd(input [8:0] c);
    begin
      @(posedge i_clk);
      cv <= c;
      i_command_strobe <= 1'b1;
      @(posedge i_clk);
      cv <= 9'h000;
      i_command_strobe <= 1'b0;
      @(negedge i_clk);
    end
  endtask
  task wait_st(input [2:0] s);
    integer k;
    begin
      k = 0;
      while (o_state !== s && k < 8000) begin
        @(negedge i_clk);
        k = k + 1;
      end
      check(o_state, s);
    end
  endtask
  task test_done;
    begin
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    repeat (60000) @(posedge i_clk);
    n_fail = n_fail + 1;
    test_done;
  end
  initial begin
    i_srst = 1'b1; i_command_strobe = 1'b0; cv = 9'h000; md = 4'h0;
    i_stop_space_n = 1'b1; i_halt = 1'b0;
    i_tape_start_marker = 1'b0; i_dual_gap_unit = 1'b0;
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    @(negedge i_clk);
    check({o_command_busy_flag, o_transfer_active_flag, o_state}, 8'h00);
    cmd(9'h088); check({o_command_busy_flag, o_state}, 8'h00);
    cmd(9'h001);
    check({o_command_busy_flag, o_offline_pulse, o_state}, 8'h08);
    cmd(9'h002);
    check({o_command_busy_flag, o_rewind_pulse, o_state}, 8'h1f);
    cmd(9'h001); check({o_offline_pulse, o_state}, 8'h0f);
    wait_st(3'h0);
    @(posedge i_clk) md <= 4'hf;
    cmd(9'h008); check({o_forward_motion_request, o_state}, 8'h09);
    check({o_threshold_high, o_threshold_low, o_edit, o_diag_readback},
      8'h0f);
    cmd(9'h080); check({o_status_clear, o_state}, 8'h01);
    wait_st(3'h3); check(o_transfer_active_flag, 8'h01);
    wait_st(3'h4); wait_st(3'h5);
    check({o_transfer_active_flag, o_forward_motion_request}, 8'h00);
    cmd(9'h008); check(o_state, 8'h01);
    cmd(9'h004); check({o_status_clear, o_state}, 8'h0f);
    wait_st(3'h0);
    @(posedge i_clk) md <= 4'h0;
    @(posedge i_clk) i_tape_start_marker <= 1'b1;
    cmd(9'h010); check({o_forward_motion_request, o_state}, 8'h0a);
    @(posedge i_clk) i_tape_start_marker <= 1'b0;
    @(posedge i_clk) i_stop_space_n <= 1'b0;
    wait_st(3'h3); repeat (200) @(negedge i_clk);
    check(o_state, 8'h03);
    @(posedge i_clk) i_stop_space_n <= 1'b1;
    wait_st(3'h4); wait_st(3'h0);
    cmd(9'h100); check({o_backward_motion_request, o_state}, 8'h09);
    wait_st(3'h3);
    @(posedge i_clk) i_tape_start_marker <= 1'b1;
    repeat (3) @(negedge i_clk);
    check(o_state, 8'h04);
    @(posedge i_clk) i_tape_start_marker <= 1'b0;
    wait_st(3'h6); wait_st(3'h0);
    cmd(9'h020); check(o_state, 8'h02);
    wait_st(3'h3); repeat (2) @(negedge i_clk);
    check(o_state, 8'h04);
    wait_st(3'h0);
    cmd(9'h080); check(o_write_enable, 8'h01);
    wait_st(3'h3); repeat (40) @(negedge i_clk);
    check(o_state, 8'h03);
    @(posedge i_clk) i_halt <= 1'b1;
    wait_st(3'h4);
    @(posedge i_clk) i_halt <= 1'b0;
    wait_st(3'h0);
    @(posedge i_clk) i_dual_gap_unit <= 1'b1;
    cmd(9'h040); wait_st(3'h3); repeat (48) @(negedge i_clk);
    check(o_state, 8'h03);
    wait_st(3'h4); wait_st(3'h0);
    test_done;
  end
endmodule // test_tfcs_sequencer
